// File: logic/psp_top.sv
// Serial control port with register file and shared readback/general output pin.
// Assumes serial pins come from another domain; source signals and local port on I_CLK.
//
// What this block does
// RQ1 - Master sends 24 data bits first, MSB first, changing on falling edges.
// RQ2 - Device samples serial input on rising clock edges, data on first 24.
// RQ3 - Five register address bits follow, MSB first, sampled on edges 25-29.
// RQ4 - Last three bits are chip address; only address zero is accepted.
// RQ5 - Master raises latch strobe after the 32nd rising edge, then lowers it.
// RQ6 - Register commit happens on latch strobe rise, never on a clock edge.
// RQ7 - Every frame after a strobe shifts out the register chosen by the read pointer.
// RQ8 - To read, master writes register zero with target address in bits 4-0.
// RQ9 - Second read frame repeats the register-zero write when nothing new is wanted.
// RQ10 - Second frame puts selected data on the pin, switching away from general output.
// RQ11 - Readback needs no strobe; pin returns to general output on strobe rise.
// RQ12 - After reset the driver is off and drives only on addressed reads.
// RQ13 - Driver enabled when last three bits before strobe are zero.
// RQ14 - Override bit 0Fh[6] keeps general output on the pin during reads.
// RQ15 - Clearing 08h[5] disables the driver above all other controls.
// RQ16 - Bits 0Fh[8] and 0Fh[9] disable pull-up and pull-down halves.
// RQ17 - Field 0Fh[4:0] picks the general output signal, default lock detect.
// RQ18 - Hold-on bit 0Fh[7] keeps driver on outside reads.
// RQ19 - Keep-on bits in 01h hold chosen blocks active in power-down.
// RQ20 - Register 00h reads back a fixed identity word.
// RQ21 - Eight chips share a bus; writes need three wires, reads four.
// RQ22 - Serial clock stays at or below 50 MHz.
// RQ23 - Writing register zero bit 5 as one soft-resets the registers.
// RQ24 - With 01h[0] clear, power follows 01h[1] and the enable pin is ignored.
// RQ25 - Last 32 bits before strobe form the frame; count restarts per strobe.
`include "psp_defs.svh"
module psp_top
(
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // Serial link
  input  wire logic        I_SCK,
  input  wire logic        I_SDI,
  input  wire logic        I_LATCH,
  input  wire logic        I_CHIP_EN,
  // General output sources, index 1 is lock detect
  input  wire logic [31:0] I_GPO_SRC,
  // Local register port
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [23:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [23:0] O_RDATA,
  // Shared readback pin
  output logic             O_PIN_O,
  output logic             O_PIN_OE,
  output logic             O_PU_DIS,
  output logic             O_PD_DIS,
  // Power control
  output logic             O_PWR_EN,
  output logic      [4:0]  O_BLOCK_ON,
  output logic             O_SOFT_RST
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [23:0] reset_val(input logic [4:0] idx);
    case (idx)
      `PSP_REG_PWR: reset_val = `PSP_PWR_RST;
      `PSP_REG_DRV: reset_val = `PSP_DRV_RST;
      `PSP_REG_GPO: reset_val = `PSP_GPO_RST;
      default:      reset_val = 24'h000000;
    endcase
  endfunction : reset_val

  psp_pkg::psp_edge_t sck_e, sdi_e, lat_e, cen_e;
  logic [23:0]        regs_ff [0:31];
  logic [23:0]        nxt_regs [0:31];
  logic [23:0]        stat_word;
  logic               gpo_sig;

  function automatic logic [23:0] reg_read(input logic [4:0] idx);
    case (idx)
      `PSP_REG_ID:   reg_read = `PSP_ID_WORD;  // RQ20
      `PSP_REG_STAT: reg_read = stat_word;
      default:       reg_read = regs_ff[idx];
    endcase
  endfunction : reg_read

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  psp_sync u_sck (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_SCK),     .o_edge(sck_e));
  psp_sync u_sdi (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_SDI),     .o_edge(sdi_e));
  psp_sync u_lat (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_LATCH),   .o_edge(lat_e));
  psp_sync u_cen (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_CHIP_EN), .o_edge(cen_e));

  // ---------------------------------------------------------------
  // Frame shifter
  // ---------------------------------------------------------------
  psp_pkg::psp_fstate_t fs_ff, nxt_fs;
  logic [31:0]          shift_ff, nxt_shift;
  logic [5:0]           cnt_ff, nxt_cnt;
  logic [23:0]          shadow_ff, nxt_shadow;
  logic                 sdo_ff, nxt_sdo;
  logic                 rd_arm_ff, nxt_rd_arm;
  logic                 read_mode_ff, nxt_read_mode;
  logic [4:0]           ptr_ff, nxt_ptr;
  logic                 addressed;
  logic                 commit;
  logic                 srst_req;
  logic [4:0]           ptr_new;

  // Chip bits are checked without a full frame, so an early strobe with zeros there counts as ours
  assign addressed = (shift_ff[2:0] == 3'b000);  // RQ13 RQ21
  assign commit    = lat_e.rise && (fs_ff == psp_pkg::FS_FULL) && addressed;  // RQ4 RQ6
  assign ptr_new   = (commit && shift_ff[7:3] == `PSP_REG_ID) ? shift_ff[8+`PSP_PTR_HI:8] : ptr_ff;
  assign srst_req  = commit && (shift_ff[7:3] == `PSP_REG_ID) && shift_ff[8+`PSP_SRST_BIT];

  always_comb
  begin
    nxt_fs        = fs_ff;
    nxt_shift     = shift_ff;
    nxt_cnt       = cnt_ff;
    nxt_shadow    = shadow_ff;
    nxt_sdo       = sdo_ff;
    nxt_rd_arm    = rd_arm_ff;
    nxt_read_mode = read_mode_ff;
    nxt_ptr       = ptr_new;  // RQ7
    if (lat_e.rise)
    begin
      // Frame closes: restart count, reload readback word
      nxt_fs        = psp_pkg::FS_IDLE;  // RQ25
      nxt_shift     = 32'h00000000;
      nxt_cnt       = 6'h00;
      nxt_rd_arm    = addressed;  // RQ13
      nxt_read_mode = 1'b0;  // RQ11
      nxt_shadow    = (ptr_new == `PSP_REG_ID) ? `PSP_ID_WORD :
                      (ptr_new == `PSP_REG_STAT) ? stat_word : regs_ff[ptr_new];
    end
    else if (sck_e.rise)
    begin
      nxt_shift  = {shift_ff[30:0], sdi_e.lvl};  // RQ2 RQ3
      nxt_sdo    = shadow_ff[23];  // RQ7
      nxt_shadow = {shadow_ff[22:0], 1'b0};
      if (cnt_ff != `PSP_FRAME_BITS)
        nxt_cnt = cnt_ff + 6'h01;
      if (rd_arm_ff)
        nxt_read_mode = 1'b1;  // RQ10
      case (fs_ff)
        psp_pkg::FS_IDLE:  nxt_fs = psp_pkg::FS_SHIFT;
        psp_pkg::FS_SHIFT: nxt_fs = (cnt_ff == `PSP_FRAME_BITS - 6'h01) ? psp_pkg::FS_FULL : psp_pkg::FS_SHIFT;
        psp_pkg::FS_FULL:  nxt_fs = psp_pkg::FS_FULL;  // RQ25
        default:           nxt_fs = psp_pkg::FS_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      fs_ff        <= psp_pkg::FS_IDLE;
      shift_ff     <= 32'h00000000;
      cnt_ff       <= 6'h00;
      shadow_ff    <= 24'h000000;
      sdo_ff       <= 1'b0;
      rd_arm_ff    <= 1'b0;
      read_mode_ff <= 1'b0;
      ptr_ff       <= 5'h00;
    end
    else
    begin
      fs_ff        <= nxt_fs;
      shift_ff     <= nxt_shift;
      cnt_ff       <= nxt_cnt;
      shadow_ff    <= nxt_shadow;
      sdo_ff       <= nxt_sdo;
      rd_arm_ff    <= nxt_rd_arm;
      read_mode_ff <= nxt_read_mode;
      ptr_ff       <= nxt_ptr;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Serial commit wins over a local write in the same cycle
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      nxt_regs[i] = regs_ff[i];
    if (srst_req)
    begin
      for (int i = 0; i < 32; i++)
        nxt_regs[i] = reset_val(5'(i));  // RQ23
    end
    else if (commit && shift_ff[7:3] != `PSP_REG_ID && shift_ff[7:3] != `PSP_REG_STAT)
    begin
      nxt_regs[shift_ff[7:3]] = (shift_ff[7:3] == `PSP_REG_PWR) ? (shift_ff[31:8] & `PSP_PWR_MASK)
                                                                 : shift_ff[31:8];  // RQ6
    end
    else if (!commit && I_WR && I_ADDR != `PSP_REG_ID && I_ADDR != `PSP_REG_STAT)
    begin
      nxt_regs[I_ADDR] = (I_ADDR == `PSP_REG_PWR) ? (I_WDATA & `PSP_PWR_MASK) : I_WDATA;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      for (int i = 0; i < 32; i++)
        regs_ff[i] <= reset_val(5'(i));
    end
    else
    begin
      for (int i = 0; i < 32; i++)
        regs_ff[i] <= nxt_regs[i];
    end
  end

  // ---------------------------------------------------------------
  // Pin and power outputs
  // ---------------------------------------------------------------
  logic [23:0]         pwr_r, drv_r, gpo_r;
  logic                pwr_on;
  psp_pkg::psp_pin_t   pin_ff, nxt_pin;
  logic [4:0]          blk_ff, nxt_blk;
  logic                pwr_ff, srst_ff;
  logic [23:0]         rdata_ff, nxt_rdata;

  assign pwr_r     = regs_ff[`PSP_REG_PWR];
  assign drv_r     = regs_ff[`PSP_REG_DRV];
  assign gpo_r     = regs_ff[`PSP_REG_GPO];
  assign pwr_on    = pwr_r[`PSP_PWR_PINSEL] ? cen_e.lvl : pwr_r[`PSP_PWR_SWEN];  // RQ24
  assign stat_word = {10'h000, pwr_on, read_mode_ff, rd_arm_ff, ptr_ff, cnt_ff};

  psp_gpo_mux u_mux
  (
    .i_sel (gpo_r[`PSP_GPO_SEL_HI:0]),  // RQ17
    .i_src (I_GPO_SRC),
    .o_sig (gpo_sig)
  );

  always_comb
  begin
    // Readback takes the pin unless overridden
    nxt_pin.o      = (read_mode_ff && !gpo_r[`PSP_GPO_OVR]) ? sdo_ff : gpo_sig;  // RQ10 RQ14
    // Master enable bit gates every other drive request
    nxt_pin.oe     = drv_r[`PSP_DRV_EN] && (read_mode_ff || gpo_r[`PSP_GPO_HOLD]);  // RQ12 RQ15 RQ18
    nxt_pin.pu_dis = gpo_r[`PSP_GPO_PU_DIS];  // RQ16
    nxt_pin.pd_dis = gpo_r[`PSP_GPO_PD_DIS];  // RQ16
    nxt_blk        = {pwr_on | pwr_r[`PSP_KEEP_PADS], pwr_on | pwr_r[`PSP_KEEP_BUF],
                      pwr_on | pwr_r[`PSP_KEEP_CP], pwr_on | pwr_r[`PSP_KEEP_PFD],
                      pwr_on | pwr_r[`PSP_KEEP_BIAS]};  // RQ19
    nxt_rdata      = I_RD ? reg_read(I_ADDR) : rdata_ff;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pin_ff   <= '0;
      blk_ff   <= 5'h00;
      pwr_ff   <= 1'b0;
      srst_ff  <= 1'b0;
      rdata_ff <= 24'h000000;
    end
    else
    begin
      pin_ff   <= nxt_pin;
      blk_ff   <= nxt_blk;
      pwr_ff   <= pwr_on;
      srst_ff  <= srst_req;
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_PIN_O    = pin_ff.o;
  assign O_PIN_OE   = pin_ff.oe;
  assign O_PU_DIS   = pin_ff.pu_dis;
  assign O_PD_DIS   = pin_ff.pd_dis;
  assign O_BLOCK_ON = blk_ff;
  assign O_PWR_EN   = pwr_ff;
  assign O_SOFT_RST = srst_ff;
  assign O_RDATA    = rdata_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  a_drv_master_off: assert property (!drv_r[`PSP_DRV_EN] |=> !O_PIN_OE)  // RQ15
    else $error("driver on while master enable clear");
  a_ovr_keeps_gpo: assert property (gpo_r[`PSP_GPO_OVR] |=> O_PIN_O == $past(gpo_sig))  // RQ14
    else $error("readback reached pin despite override");
  a_commit_on_latch: assert property ($changed(regs_ff[`PSP_REG_GPO]) |-> $past(lat_e.rise || I_WR))  // RQ6
    else $error("register changed without strobe or write");
  a_shift_on_rise: assert property ($changed(shift_ff) |-> $past(sck_e.rise || lat_e.rise))  // RQ2
    else $error("shifter moved without clock rise");
  a_cnt_restart: assert property (lat_e.rise |=> cnt_ff == 6'h00 && fs_ff == psp_pkg::FS_IDLE)  // RQ25
    else $error("bit count not restarted by strobe");
  a_read_ident: assert property (I_RD && I_ADDR == `PSP_REG_ID |=> O_RDATA == `PSP_ID_WORD)  // RQ20
    else $error("identity word wrong");
  a_read_exit: assert property (read_mode_ff && lat_e.rise |=> !read_mode_ff)  // RQ11
    else $error("readback not left on strobe");
  a_chip_reject: assert property (lat_e.rise && !addressed |=> $stable(ptr_ff) && !rd_arm_ff)  // RQ4
    else $error("foreign chip address accepted");
  a_hold_drive: assert property (drv_r[`PSP_DRV_EN] && gpo_r[`PSP_GPO_HOLD] |=> O_PIN_OE)  // RQ18
    else $error("hold-on did not keep driver on");
  a_pwr_select: assert property (!pwr_r[`PSP_PWR_PINSEL] |=> O_PWR_EN == $past(pwr_r[`PSP_PWR_SWEN]))  // RQ24
    else $error("power not following software enable");
  a_soft_reset: assert property (srst_req |=> regs_ff[`PSP_REG_GPO] == `PSP_GPO_RST ##0 O_SOFT_RST)  // RQ23
    else $error("soft reset did not restore defaults");
endmodule : psp_top

// File: logic/psp_defs.svh
// Constants of the serial control port: offsets, field positions, reset values, counts.
// Assumes inclusion by bare name from the design files.
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH
// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define PSP_REG_ID      5'h00
`define PSP_REG_PWR     5'h01
`define PSP_REG_DRV     5'h08
`define PSP_REG_GPO     5'h0F
`define PSP_REG_STAT    5'h1F
// ---------------------------------------------------------------
// Reset values (identity value is arbitrary)
// ---------------------------------------------------------------
`define PSP_ID_WORD     24'h5A3C11
`define PSP_PWR_RST     24'h000003
`define PSP_PWR_MASK    24'h0003FF
`define PSP_DRV_RST     24'h000020
`define PSP_GPO_RST     24'h000001
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PSP_PTR_HI      4
`define PSP_SRST_BIT    5
`define PSP_PWR_PINSEL  0
`define PSP_PWR_SWEN    1
`define PSP_KEEP_BIAS   2
`define PSP_KEEP_PFD    3
`define PSP_KEEP_CP     4
`define PSP_KEEP_BUF    6
`define PSP_KEEP_PADS   7
`define PSP_DRV_EN      5
`define PSP_GPO_SEL_HI  4
`define PSP_GPO_OVR     6
`define PSP_GPO_HOLD    7
`define PSP_GPO_PU_DIS  8
`define PSP_GPO_PD_DIS  9
// ---------------------------------------------------------------
// Frame counts
// ---------------------------------------------------------------
`define PSP_FRAME_BITS  6'h20
`define PSP_DATA_BITS   6'h18
`endif

// File: logic/psp_pkg.sv
// Types shared by the serial control port modules.
// Assumes psp_defs.svh for numeric constants.
package psp_pkg;
  // Synchronised pin with its edges
  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } psp_edge_t;

  // Drive of the shared output pin
  typedef struct packed {
    logic o;
    logic oe;
    logic pu_dis;
    logic pd_dis;
  } psp_pin_t;

  typedef enum logic [1:0] {
    FS_IDLE  = 2'b00,
    FS_SHIFT = 2'b01,
    FS_FULL  = 2'b10
  } psp_fstate_t;
endpackage : psp_pkg

// File: logic/psp_sync.sv
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes an asynchronous pin input; outputs are registered on i_clk.
module psp_sync
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Pin and result
  input  wire logic              i_pin,
  output psp_pkg::psp_edge_t     o_edge
);
  logic               s1_ff, s2_ff, s3_ff;
  logic               lvl_ff;
  psp_pkg::psp_edge_t edge_ff;
  logic               nxt_lvl;
  psp_pkg::psp_edge_t nxt_edge;

  always_comb
  begin
    nxt_lvl  = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
    nxt_edge = '{lvl: nxt_lvl, rise: nxt_lvl & ~lvl_ff, fall: ~nxt_lvl & lvl_ff};
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      lvl_ff  <= 1'b0;
      edge_ff <= '0;
    end
    else
    begin
      s1_ff   <= i_pin;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      lvl_ff  <= nxt_lvl;
      edge_ff <= nxt_edge;
    end
  end

  assign o_edge = edge_ff;
endmodule : psp_sync

// File: logic/psp_gpo_mux.sv
// Selector of the exported general-purpose signal.
// Assumes source signals already in the i_clk domain.
module psp_gpo_mux
(
  // Selection
  input  wire logic [4:0]  i_sel,
  input  wire logic [31:0] i_src,
  // Result
  output logic             o_sig
);
  always_comb
  begin
    o_sig = i_src[i_sel];
  end
endmodule : psp_gpo_mux

// File: sim/psp_spi_master.sv
// Host master model for the serial link of the control port.
// Assumes the bench calls xfer from one process; link clock idles low.
module psp_spi_master
(
  // Serial link
  output logic      o_sck,
  output logic      o_sdi,
  output logic      o_latch,
  // Shared pin as seen on the board
  input  wire logic i_pin_o,
  input  wire logic i_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_sck   = 1'b0;
    o_sdi   = 1'b0;
    o_latch = 1'b0;
  end

  // ---------------------------------------------------------------
  // One frame, MSB first, 800 ns link clock
  // ---------------------------------------------------------------
  // Pin is sampled just before the next rise, where each bit still stands
  task automatic xfer(input logic [31:0] frm, input int nbits, input logic strobe,
                      output logic [31:0] got, output logic oe_last);
    got     = 32'h0;
    oe_last = 1'b0;
    #37;
    for (int i = 0; i < nbits; i++)
    begin
      o_sdi = frm[nbits-1-i];
      #400;
      if (i > 0)
        got = {got[30:0], i_pin_o};
      o_sck = 1'b1;
      #400;
      o_sck = 1'b0;
    end
    // Released line must not keep showing the last bit
    o_sdi = ~o_sdi;
    #400;
    got     = {got[30:0], i_pin_o};
    oe_last = i_pin_oe;
    if (strobe)
    begin
      o_latch = 1'b1;
      #800;
      o_latch = 1'b0;
    end
    #800;
  endtask : xfer
endmodule : psp_spi_master

// File: sim/psp_top_tb_top.sv
// Self-checking bench of the serial control port and its shared pin.
// Assumes psp_spi_master as the link partner and the local port for setup.
`include "psp_defs.svh"
module psp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk;
  logic        rst_n;
  logic        sck;
  logic        sdi;
  logic        latch;
  logic        chip_en;
  logic [31:0] gpo_src;
  logic [4:0]  addr;
  logic [23:0] wdata;
  logic        wr;
  logic        rd;
  logic [23:0] rdata;
  logic        pin_o;
  logic        pin_oe;
  logic        pu_dis;
  logic        pd_dis;
  logic        pwr_en;
  logic [4:0]  block_on;
  logic        soft_rst;
  logic [31:0] got;
  logic        oe;
  int          bad_count;
  int          tests_run;
  int          cycles;
  int          srst_seen;
  int          keep_pos [5] = '{2, 3, 4, 6, 7};

  psp_top i_psp_top (.I_CLK(clk), .I_RST_N(rst_n), .I_SCK(sck), .I_SDI(sdi), .I_LATCH(latch),
    .I_CHIP_EN(chip_en), .I_GPO_SRC(gpo_src), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .O_PIN_O(pin_o), .O_PIN_OE(pin_oe), .O_PU_DIS(pu_dis),
    .O_PD_DIS(pd_dis), .O_PWR_EN(pwr_en), .O_BLOCK_ON(block_on), .O_SOFT_RST(soft_rst));

  psp_spi_master i_psp_spi_master (.o_sck(sck), .o_sdi(sdi), .o_latch(latch),
    .i_pin_o(pin_o), .i_pin_oe(pin_oe));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic reg_wr(input logic [4:0] a, input logic [23:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [4:0] a, input logic [23:0] exp, input string what);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_chk

  task automatic frame(input logic [4:0] r, input logic [23:0] d, input logic [2:0] c,
                       input logic strobe);
    i_psp_spi_master.xfer({d, r, c}, 32, strobe, got, oe);
  endtask : frame

  task automatic settle();
    repeat (2) @(negedge clk);
  endtask : settle

  // Hang guard, also counts soft reset pulses
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (soft_rst === 1'b1)
      srst_seen <= srst_seen + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_n     = 1'b0;
    chip_en   = 1'b1;
    gpo_src   = 32'h0000_0022;
    addr      = 5'h00;
    wdata     = 24'h000000;
    wr        = 1'b0;
    rd        = 1'b0;
    bad_count = 0;
    tests_run = 0;
    cycles    = 0;
    srst_seen = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("oe idle", 1'b0, pin_oe);
    rd_chk(5'h00, `PSP_ID_WORD, "id");
    rd_chk(5'h01, 24'h000003, "r01");
    rd_chk(5'h08, 24'h000020, "r08");
    rd_chk(5'h0F, 24'h000001, "r0F");
    rd_chk(5'h1A, 24'h000000, "r1A");
    reg_wr(5'h00, 24'h123456);
    rd_chk(5'h00, `PSP_ID_WORD, "id ro");
    frame(5'h0F, 24'h000005, 3'h0, 1'b0);
    rd_chk(5'h0F, 24'h000001, "no strobe");
    frame(5'h0F, 24'h000005, 3'h0, 1'b1);
    rd_chk(5'h0F, 24'h000005, "serial wr");
    frame(5'h0F, 24'h000009, 3'h5, 1'b1);
    chk("armed oe", 1'b1, oe);
    chk("rb id", {`PSP_ID_WORD, 8'h00}, got);
    rd_chk(5'h0F, 24'h000005, "foreign wr");
    frame(5'h0F, 24'h000009, 3'h5, 1'b1);
    chk("foreign oe", 1'b0, oe);
    // Two-cycle read of a local value
    reg_wr(5'h04, 24'hA55A3C);
    frame(5'h00, 24'h000004, 3'h0, 1'b1);
    frame(5'h00, 24'h000004, 3'h0, 1'b0);
    chk("readback", 32'hA55A3C00, got);
    chk("oe read", 1'b1, oe);
    // Word is used up after 24 shifts; pin stays on readback until a strobe
    chk("no strobe mode", {1'b1, 1'b0}, {pin_oe, pin_o});
    frame(5'h00, 24'h000004, 3'h0, 1'b1);
    chk("readback 2", 32'h00000000, got);
    chk("pin after", {1'b0, gpo_src[5]}, {pin_oe, pin_o});
    // Strobe before a full frame still arms, stores nothing
    frame(5'h00, 24'h000004, 3'h5, 1'b1);
    i_psp_spi_master.xfer(32'h0, 3, 1'b1, got, oe);
    frame(5'h00, 24'h000004, 3'h0, 1'b1);
    chk("short arm oe", 1'b1, oe);
    chk("short no wr", 32'hA55A3C00, got);
    // Override and hold-on
    reg_wr(5'h0F, 24'h000085);
    settle();
    chk("hold idle", {1'b1, gpo_src[5]}, {pin_oe, pin_o});
    frame(5'h00, 24'h000004, 3'h0, 1'b1);
    chk("hold read", 32'hA55A3C00, got);
    reg_wr(5'h0F, 24'h0000C5);
    frame(5'h00, 24'h000004, 3'h0, 1'b1);
    chk("ovr read", 32'hFFFFFFFF, got);
    chk("ovr oe", 1'b1, oe);
    reg_wr(5'h08, 24'h000000);
    settle();
    chk("drv off", 1'b0, pin_oe);
    frame(5'h00, 24'h000004, 3'h0, 1'b1);
    chk("drv off rd", 1'b0, oe);
    reg_wr(5'h08, 24'h000020);
    reg_wr(5'h0F, 24'h000300);
    settle();
    chk("pull both", 2'b11, {pu_dis, pd_dis});
    reg_wr(5'h0F, 24'h000100);
    settle();
    chk("pull up", 2'b10, {pu_dis, pd_dis});
    // Power control
    chip_en <= 1'b0;
    repeat (8) @(negedge clk);
    chk("pwr pin", 6'h00, {pwr_en, block_on});
    reg_wr(5'h01, 24'h000002);
    settle();
    chk("pwr sw", 6'h3F, {pwr_en, block_on});
    for (int k = 0; k < 5; k++)
    begin
      reg_wr(5'h01, 24'h000001 << keep_pos[k]);
      settle();
      chk("keep on", {1'b0, 5'h01 << k}, {pwr_en, block_on});
    end
    // Soft reset through register zero
    frame(5'h00, 24'h000020, 3'h0, 1'b1);
    chk("srst pulse", 1, srst_seen);
    rd_chk(5'h0F, 24'h000001, "srst r0F");
    rd_chk(5'h01, 24'h000003, "srst r01");
    give_verdict();
  end
endmodule : psp_top_tb_top
